// ---- hdl/oscsc_pkg.sv ----
package oscsc_pkg;
  localparam logic [4:0] ADDR_STATUS     = 5'h03;
  localparam logic [4:0] ADDR_FAST_CTRL  = 5'h10;
  localparam logic [4:0] ADDR_TRIM_A     = 5'h11;
  localparam logic [4:0] ADDR_TRIM_B     = 5'h12;
  localparam logic [4:0] ADDR_SLOW_CTRL  = 5'h18;
  localparam logic [4:0] ADDR_XTAL_CTRL  = 5'h1C;
  localparam logic [4:0] ADDR_MAIN_SEL   = 5'h00;
  localparam logic [4:0] ADDR_UNLOCK     = 5'h04;
  localparam logic [7:0] UNLOCK_KEY      = 8'hD8;
  localparam int         UNLOCK_WINDOW   = 4;
  localparam int         KEEP_BIT        = 1;
  localparam int         XEN_BIT         = 0;
  localparam int         XSEL_BIT        = 2;
  localparam int         CRYSTAL_STARTUP_COUNT_LO         = 4;
  localparam int         FREEZE_BIT      = 7;
  localparam int         ST_EXT          = 7;
  localparam int         ST_XTAL         = 6;
  localparam int         ST_ULP          = 5;
  localparam int         ST_FAST         = 4;
  localparam int         ST_SWITCH       = 0;
  localparam int         GATE_CYCLES     = 4;
  // Warm crystal gate: two ticks, the output flop makes up the third cycle.
  localparam int         XTAL_GATE_CYCLES = 2;
  localparam int         EXT_START       = 2;
  localparam logic [17:0] CRYSTAL_STARTUP_COUNT_1K  = 18'h00400;
  localparam logic [17:0] CRYSTAL_STARTUP_COUNT_16K = 18'h04000;
  localparam logic [17:0] CRYSTAL_STARTUP_COUNT_32K = 18'h08000;
  localparam logic [17:0] CRYSTAL_STARTUP_COUNT_64K = 18'h10000;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  typedef enum logic [1:0] {
    OSCSC_SRC_FAST = 2'b00,
    OSCSC_SRC_ULP  = 2'b01,
    OSCSC_SRC_XTAL = 2'b10,
    OSCSC_SRC_EXT  = 2'b11
  } oscsc_src_e;
endpackage : oscsc_pkg

// ---- hdl/oscsc_osc_gate.sv ----
`timescale 1ns/1ps
// Start-up and gate model of one source, ticked by its oscillator edges.
module oscsc_osc_gate #(
  parameter int GATE_N = oscsc_pkg::GATE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  input  wire logic        run_i,
  input  wire logic        req_i,
  input  wire logic [17:0] startup_i,
  output logic             stable_o,
  output logic             gate_o
);
  logic [17:0] warm_q;
  logic        warm_done_q;
  logic [2:0]  gate_cnt_q;

  // Analog start-up count while the oscillator is running.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      warm_q      <= 18'h00000;
      warm_done_q <= 1'b0;
    end else if (tick_i && !warm_done_q) begin
      if (warm_q >= startup_i) begin
        warm_done_q <= 1'b1;
      end else begin
        warm_q <= warm_q + 18'h00001;
      end
    end
  end

  // Gate opens a fixed number of oscillator edges after request and warm-up.
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || !run_i) begin
      gate_cnt_q <= 3'h0;
    end else if (tick_i && warm_done_q && gate_cnt_q != 3'(GATE_N)) begin
      gate_cnt_q <= gate_cnt_q + 3'h1;
    end
  end

  assign stable_o = warm_done_q && req_i;
  assign gate_o   = (gate_cnt_q == 3'(GATE_N));
endmodule : oscsc_osc_gate

// ---- hdl/oscsc_top.sv ----
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
// Oscillator status and control register block on classic Wishbone.
module oscsc_top (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [6:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       cpu_instr_i,
  input  wire logic [5:0] fuse_freq_trim_i,
  input  wire logic [3:0] fuse_slope_trim_i,
  input  wire logic       fuse_trim_freeze_i,
  input  wire logic       fast_osc_edge_i,
  input  wire logic       ulp_osc_edge_i,
  input  wire logic       crystal_edge_i,
  input  wire logic       ext_clock_edge_i,
  input  wire logic [3:0] periph_req_i,
  output logic [3:0]      periph_gate_o,
  output logic [1:0]      main_source_o,
  output logic            fast_osc_run_o,
  output logic            ulp_osc_run_o,
  output logic            crystal_run_o,
  output logic            crystal_pin_override_o,
  output logic [5:0]      fast_osc_freq_trim_o,
  output logic [3:0]      temp_slope_trim_o
);
  // Oscillator edges come from other domains: two flops, then edge detect.
  logic [3:0] edge_s1_q;
  logic [3:0] edge_s2_q;
  logic [3:0] edge_s3_q;
  logic [3:0] tick;
  logic [3:0] req_s1_q;
  logic [3:0] req_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_s1_q <= 4'h0;
      edge_s2_q <= 4'h0;
      edge_s3_q <= 4'h0;
      req_s1_q  <= 4'h0;
      req_q     <= 4'h0;
    end else begin
      edge_s1_q <= {ext_clock_edge_i, crystal_edge_i, ulp_osc_edge_i, fast_osc_edge_i};
      edge_s2_q <= edge_s1_q;
      edge_s3_q <= edge_s2_q;
      req_s1_q  <= periph_req_i;
      req_q     <= req_s1_q;
    end
  end
  assign tick = edge_s2_q & ~edge_s3_q;

  // Registers.
  logic       fast_keep_q;
  logic       ulp_keep_q;
  logic [5:0] freq_trim_q;
  logic [3:0] slope_trim_q;
  logic       freeze_q;
  logic       x_en_q;
  logic       x_keep_q;
  logic       x_sel_q;
  logic [1:0] x_crystal_startup_count_q;
  logic [1:0] main_sel_q;
  logic [1:0] cur_src_q;
  logic [2:0] unlock_cnt_q;
  logic [7:0] status;

  // Bus decode: word address is the printed offset.
  logic [4:0] reg_idx;
  logic       hit;
  logic       wr;
  logic       prot_ok;
  assign reg_idx = wb_adr_i[6:2];
  assign hit     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = hit && wb_we_i && wb_sel_i[0];
  assign prot_ok = (unlock_cnt_q != 3'h0);

  // Unlock window counts down one per instruction after the key write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_cnt_q <= 3'h0;
    end else if (wr && reg_idx == oscsc_pkg::ADDR_UNLOCK
                 && wb_dat_i[7:0] == oscsc_pkg::UNLOCK_KEY) begin
      unlock_cnt_q <= 3'(oscsc_pkg::UNLOCK_WINDOW);
    end else if (wr && prot_ok && reg_idx != oscsc_pkg::ADDR_STATUS) begin
      unlock_cnt_q <= 3'h0;
    end else if (cpu_instr_i && prot_ok) begin
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
    end
  end

  // RC oscillator keep-running bits, protected.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_keep_q <= 1'b0;
      ulp_keep_q  <= 1'b0;
    end else if (wr && prot_ok) begin
      if (reg_idx == oscsc_pkg::ADDR_FAST_CTRL) begin
        fast_keep_q <= wb_dat_i[oscsc_pkg::KEEP_BIT];
      end
      if (reg_idx == oscsc_pkg::ADDR_SLOW_CTRL) begin
        ulp_keep_q <= wb_dat_i[oscsc_pkg::KEEP_BIT];
      end
    end
  end

  // Trim registers load fuse values in reset; freeze blocks writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_trim_q  <= fuse_freq_trim_i;
      slope_trim_q <= fuse_slope_trim_i;
      freeze_q     <= fuse_trim_freeze_i;
    end else if (wr && prot_ok && !freeze_q) begin
      if (reg_idx == oscsc_pkg::ADDR_TRIM_A) begin
        freq_trim_q <= wb_dat_i[5:0];
      end
      if (reg_idx == oscsc_pkg::ADDR_TRIM_B) begin
        slope_trim_q <= wb_dat_i[3:0];
      end
    end
  end

  // Crystal control: enable and keep-running protected, type/count frozen while enabled or stable.
  logic x_stable;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_en_q   <= 1'b0;
      x_keep_q <= 1'b0;
      x_sel_q  <= 1'b0;
      x_crystal_startup_count_q <= 2'h0;
    end else if (wr && prot_ok && reg_idx == oscsc_pkg::ADDR_XTAL_CTRL) begin
      x_en_q   <= wb_dat_i[oscsc_pkg::XEN_BIT];
      x_keep_q <= wb_dat_i[oscsc_pkg::KEEP_BIT];
      if (!x_en_q && !x_stable) begin
        x_sel_q  <= wb_dat_i[oscsc_pkg::XSEL_BIT];
        x_crystal_startup_count_q <= wb_dat_i[oscsc_pkg::CRYSTAL_STARTUP_COUNT_LO +: 2];
      end
    end
  end

  // Main source choice and switch tracking.
  logic [3:0] main_req;
  logic [3:0] src_stable;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_sel_q <= 2'h0;
      cur_src_q  <= 2'h0;
    end else begin
      if (wr && prot_ok && reg_idx == oscsc_pkg::ADDR_MAIN_SEL) begin
        main_sel_q <= wb_dat_i[1:0];
      end
      if (main_sel_q != cur_src_q && src_stable[main_sel_q]) begin
        cur_src_q <= main_sel_q;
      end
    end
  end

  // Requests: peripherals or use as main clock.
  logic [3:0] want;
  always_comb begin
    main_req = 4'h0;
    main_req[main_sel_q] = 1'b1;
    main_req[cur_src_q]  = 1'b1;
  end
  assign want = req_q | main_req;

  // Crystal start-up length from the count field, or EXT_START when x_sel_q is set.
  logic [17:0] x_startup;
  always_comb begin
    case (x_crystal_startup_count_q)
      2'h0:    x_startup = oscsc_pkg::CRYSTAL_STARTUP_COUNT_1K;
      2'h1:    x_startup = oscsc_pkg::CRYSTAL_STARTUP_COUNT_16K;
      2'h2:    x_startup = oscsc_pkg::CRYSTAL_STARTUP_COUNT_32K;
      2'h3:    x_startup = oscsc_pkg::CRYSTAL_STARTUP_COUNT_64K;
      default: x_startup = oscsc_pkg::CRYSTAL_STARTUP_COUNT_1K;
    endcase
    if (x_sel_q) begin
      x_startup = 18'(oscsc_pkg::EXT_START);
    end
  end

  // Run conditions per source.
  logic [3:0] run;
  assign run[0] = fast_keep_q | want[0];
  assign run[1] = ulp_keep_q | want[1];
  assign run[2] = x_en_q & (x_keep_q | want[2]);
  assign run[3] = want[3];

  // Per-source start-up and gate; keep-running skips analog start-up for the two RC oscillators only.
  logic [17:0] startup [4];
  assign startup[0] = fast_keep_q ? 18'h00000 : 18'(oscsc_pkg::GATE_CYCLES);
  assign startup[1] = ulp_keep_q ? 18'h00000 : 18'(oscsc_pkg::GATE_CYCLES);
  assign startup[2] = x_startup;
  assign startup[3] = 18'(oscsc_pkg::EXT_START);
  logic [3:0] gate;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_src
      // The crystal gate is shorter so a warm crystal answers quickly.
      oscsc_osc_gate #(
        .GATE_N ((g == 2) ? oscsc_pkg::XTAL_GATE_CYCLES : oscsc_pkg::GATE_CYCLES)
      ) u_gate (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick[g]),
        .run_i     (run[g]),
        .req_i     (want[g]),
        .startup_i (startup[g]),
        .stable_o  (src_stable[g]),
        .gate_o    (gate[g])
      );
    end
  endgenerate
  assign x_stable = src_stable[2];

  // Status byte built from synchronised flags.
  assign status = {src_stable[3], src_stable[2], src_stable[1], src_stable[0],
                   3'h0, (main_sel_q != cur_src_q)};

  // Registered outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_gate_o          <= 4'h0;
      fast_osc_run_o         <= 1'b0;
      ulp_osc_run_o          <= 1'b0;
      crystal_run_o          <= 1'b0;
      crystal_pin_override_o <= 1'b0;
    end else begin
      periph_gate_o          <= gate & req_q;
      fast_osc_run_o         <= run[0];
      ulp_osc_run_o          <= run[1];
      crystal_run_o          <= run[2];
      crystal_pin_override_o <= x_en_q;
    end
  end
  assign main_source_o        = cur_src_q;
  assign fast_osc_freq_trim_o = freq_trim_q;
  assign temp_slope_trim_o    = slope_trim_q;

  // Read mux; status writes are ignored and unmapped reads give zero.
  logic [7:0] rd;
  always_comb begin
    case (reg_idx)
      oscsc_pkg::ADDR_MAIN_SEL:  rd = {6'h00, main_sel_q};
      oscsc_pkg::ADDR_STATUS:    rd = status;
      oscsc_pkg::ADDR_FAST_CTRL: rd = {6'h00, fast_keep_q, 1'b0};
      oscsc_pkg::ADDR_TRIM_A:    rd = {2'h0, freq_trim_q};
      oscsc_pkg::ADDR_TRIM_B:    rd = {freeze_q, 3'h0, slope_trim_q};
      oscsc_pkg::ADDR_SLOW_CTRL: rd = {6'h00, ulp_keep_q, 1'b0};
      oscsc_pkg::ADDR_XTAL_CTRL: rd = {2'h0, x_crystal_startup_count_q, 1'b0, x_sel_q, x_keep_q, x_en_q};
      default:                   rd = 8'h00;
    endcase
  end

  // One-cycle acknowledge with registered read data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= hit;
      wb_dat_o <= hit ? {24'h000000, rd} : 32'h00000000;
    end
  end
endmodule : oscsc_top

// ---- verif/oscsc_osc_model.sv ----
`timescale 1ns/1ps
// Oscillator and clock-pin model; a stopped source rests low.
module oscsc_osc_model (
  input  wire logic clk_i,
  input  wire logic fast_run_i,
  input  wire logic ulp_run_i,
  input  wire logic xtal_run_i,
  input  wire logic ext_on_i,
  output logic      fast_o,
  output logic      ulp_o,
  output logic      xtal_o,
  output logic      ext_o
);
  // Each running source toggles once per clock.
  always_ff @(posedge clk_i) begin
    fast_o <= fast_run_i & ~fast_o;
    ulp_o  <= ulp_run_i & ~ulp_o;
    xtal_o <= xtal_run_i & ~xtal_o;
    ext_o  <= ext_on_i & ~ext_o;
  end
endmodule : oscsc_osc_model

// ---- verif/oscsc_top_assertions.sv ----
`timescale 1ns/1ps
// Port-level checks of the oscillator register block.
module oscsc_top_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [5:0]  fuse_freq_trim_i,
  input wire logic [3:0]  fuse_slope_trim_i,
  input wire logic        fuse_trim_freeze_i,
  input wire logic [3:0]  periph_req_i,
  input wire logic [3:0]  periph_gate_o,
  input wire logic        crystal_run_o,
  input wire logic        crystal_pin_override_o,
  input wire logic [5:0]  fast_osc_freq_trim_o,
  input wire logic [3:0]  temp_slope_trim_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic frz_q;
  // Holds the freeze fuse as sampled in reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) frz_q <= fuse_trim_freeze_i;
  end
  sequence s_fast_idle; (!periph_req_i[0])[*6]; endsequence
  sequence s_xtal_idle; (!periph_req_i[2])[*6]; endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_freq_reset: assert property (disable iff (1'b0) $fell(rst_i) |->
    fast_osc_freq_trim_o == $past(fuse_freq_trim_i)) else $error("freq trim reset");
  a_slope_reset: assert property (disable iff (1'b0) $fell(rst_i) |->
    temp_slope_trim_o == $past(fuse_slope_trim_i)) else $error("slope trim reset");
  a_trim_frozen: assert property (frz_q |=> $stable(fast_osc_freq_trim_o)
    && $stable(temp_slope_trim_o)) else $error("frozen trim moved");
  a_xtal_run_en: assert property (crystal_run_o |-> crystal_pin_override_o
    || $past(crystal_pin_override_o)) else $error("crystal runs disabled");
  a_fast_gate: assert property (s_fast_idle |-> !periph_gate_o[0])
    else $error("fast gate open unrequested");
  a_xtal_gate: assert property (s_xtal_idle |-> !periph_gate_o[2])
    else $error("crystal gate open unrequested");
endmodule : oscsc_top_assertions
bind oscsc_top oscsc_top_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fuse_freq_trim_i(fuse_freq_trim_i), .fuse_slope_trim_i(fuse_slope_trim_i),
  .fuse_trim_freeze_i(fuse_trim_freeze_i), .periph_req_i(periph_req_i),
  .periph_gate_o(periph_gate_o), .crystal_run_o(crystal_run_o),
  .crystal_pin_override_o(crystal_pin_override_o),
  .fast_osc_freq_trim_o(fast_osc_freq_trim_o), .temp_slope_trim_o(temp_slope_trim_o));

// ---- verif/oscsc_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
// Self-checking bench of the oscillator register block.
module oscsc_top_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        instr = 1'b0, frz = 1'b0, ext_on = 1'b0, ack, fr, ur, xr, fe, ue, xe, ee;
  logic [6:0]  adr = 7'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [5:0]  ff = 6'h2B;
  logic [3:0]  fs = 4'h6, req = 4'h0, gate;
  logic [1:0]  msrc;
  logic [7:0]  q;
  logic [5:0]  ft;
  logic [3:0]  st;
  logic        xov;
  int          mismatches = 0, n_compared = 0;
  // Rows: word index, unlock first, write data, read-back value.
  logic [21:0] rows [8] = '{{5'h10, 1'b1, 8'h02, 8'h02}, {5'h10, 1'b0, 8'h00, 8'h02},
    {5'h18, 1'b1, 8'h02, 8'h02}, {5'h11, 1'b1, 8'h2A, 8'h2A}, {5'h12, 1'b1, 8'h05, 8'h05},
    {5'h1C, 1'b1, 8'h34, 8'h34}, {5'h1C, 1'b1, 8'h35, 8'h35}, {5'h1C, 1'b1, 8'h03, 8'h37}};
  always #12.5 clk_i = ~clk_i;
  oscsc_top i_oscsc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpu_instr_i(instr), .fuse_freq_trim_i(ff), .fuse_slope_trim_i(fs),
    .fuse_trim_freeze_i(frz), .fast_osc_edge_i(fe), .ulp_osc_edge_i(ue),
    .crystal_edge_i(xe), .ext_clock_edge_i(ee), .periph_req_i(req), .periph_gate_o(gate),
    .main_source_o(msrc), .fast_osc_run_o(fr), .ulp_osc_run_o(ur), .crystal_run_o(xr),
    .crystal_pin_override_o(xov), .fast_osc_freq_trim_o(ft), .temp_slope_trim_o(st));
  oscsc_osc_model i_oscsc_osc_model (.clk_i(clk_i), .fast_run_i(fr), .ulp_run_i(ur),
    .xtal_run_i(xr), .ext_on_i(ext_on), .fast_o(fe), .ulp_o(ue), .xtal_o(xe), .ext_o(ee));
  // One classic Wishbone cycle, held until ack.
  task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] r);
    int t;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {a, 2'b00}; wdat <= {24'h000000, d};
    t = 0;
    do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 50);
    if (t == 50) mismatches++;
    r = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  // Key write, then n executed instructions.
  task automatic unlock(input int n);
    wb(5'h04, 1'b1, 8'hD8, q);
    repeat (n) begin @(posedge clk_i); instr <= 1'b1; @(posedge clk_i); instr <= 1'b0; end
  endtask : unlock
  // Reads until one bit reaches its value, bounded.
  task automatic poll(input logic [4:0] a, input int b, input logic e);
    int t;
    t = 0;
    do begin wb(a, 1'b0, 8'h00, q); t++; end while (q[b] !== e && t < 300);
  endtask : poll
  // Waits, bounded, for one peripheral gate.
  task automatic wgate(input int b, input logic e);
    int t;
    t = 0;
    while (gate[b] !== e && t < 300) begin @(posedge clk_i); t++; end
  endtask : wgate
  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected run.
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(5'h11, 1'b0, 8'h00, q); `CHK(q, {2'b00, ff})
    wb(5'h12, 1'b0, 8'h00, q); `CHK(q, {4'h0, fs})
    wb(5'h1C, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    wb(5'h03, 1'b0, 8'h00, q); `CHK(q[7], 1'b0)
    `CHK(ft, ff)
    `CHK(st, fs)
    foreach (rows[i]) begin
      if (rows[i][16]) unlock(0);
      wb(rows[i][21:17], 1'b1, rows[i][15:8], q);
      wb(rows[i][21:17], 1'b0, 8'h00, q); `CHK(q, rows[i][7:0])
    end
    `CHK(ft, 6'h2A)
    `CHK(st, 4'h5)
    `CHK(xov, 1'b1)
    `CHK(xr, 1'b1)
    `CHK(ur, 1'b1)
    `CHK(fr, 1'b1)
    wb(5'h07, 1'b1, 8'h55, q);
    wb(5'h07, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    wb(5'h03, 1'b1, 8'hEF, q);
    wb(5'h03, 1'b0, 8'h00, q); `CHK(q, 8'h10)
    unlock(5);
    wb(5'h18, 1'b1, 8'h00, q);
    wb(5'h18, 0, 8'h00, q); `CHK(q, 8'h02)
    req[2] <= 1'b1;
    poll(5'h03, 6, 1'b1); `CHK(q[6], 1'b1)
    wgate(2, 1'b1); `CHK(gate[2], 1'b1)
    req[2] <= 1'b0;
    poll(5'h03, 6, 1'b0); `CHK(q[6], 1'b0)
    req[1] <= 1'b1;
    poll(5'h03, 5, 1'b1); `CHK(q[5], 1'b1)
    wgate(1, 1'b1); `CHK(gate[1], 1'b1)
    req[1] <= 1'b0;
    wgate(1, 1'b0); `CHK(gate[1], 1'b0)
    ext_on <= 1'b1;
    req[3] <= 1'b1;
    poll(5'h03, 7, 1'b1); `CHK(q[7], 1'b1)
    unlock(0);
    wb(5'h00, 1'b1, 8'h01, q);
    poll(5'h03, 0, 1'b0); `CHK(msrc, oscsc_pkg::OSCSC_SRC_ULP)
    unlock(0);
    wb(5'h10, 1'b1, 8'h00, q);
    wb(5'h10, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    `CHK(fr, 1'b0)
    unlock(0);
    wb(5'h00, 1'b1, 8'h00, q);
    wb(5'h03, 1'b0, 8'h00, q); `CHK(q[0], 1'b1)
    poll(5'h03, 0, 1'b0); `CHK(msrc, oscsc_pkg::OSCSC_SRC_FAST)
    ff <= 6'h15; fs <= 4'h9; frz <= 1'b1; rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(5'h12, 1'b0, 8'h00, q); `CHK(q, 8'h89)
    unlock(0);
    wb(5'h11, 1'b1, 8'h3F, q);
    wb(5'h11, 1'b0, 8'h00, q); `CHK(q, 8'h15)
    end_sim();
  end
endmodule : oscsc_top_tb
